// ===== hdl/ros_map.svh
`ifndef ROS_MAP_SVH
`define ROS_MAP_SVH

// register byte offsets
`define ROS_SEL_OFF        8'h00
`define ROS_LEVEL_OFF      8'h04
`define ROS_ON_DLY_OFF     8'h08
`define ROS_OFF_DLY_OFF    8'h0C
`define ROS_STATUS_OFF     8'h10

// reset values
`define ROS_SEL_RST        5'h00
`define ROS_LEVEL_RST      32'h0000_0000
`define ROS_DLY_RST        16'h0000

// limits, tenths of a unit
`define ROS_LEVEL_MAX      32'h0001_8696
`define ROS_DLY_MAX        16'h1770

// status fields
`define ROS_ST_RELAY       0
`define ROS_ST_COND        1
`define ROS_ST_PEND        2
`define ROS_ST_BIPOLAR     3
`define ROS_ST_CNT_LSB     16

// selector codes
`define ROS_C_READY        5'h00
`define ROS_C_AT_SPEED     5'h01
`define ROS_C_POWERED      5'h02
`define ROS_C_LOCAL        5'h03
`define ROS_C_OVERLOAD     5'h04
`define ROS_C_RAMP_REG     5'h05
`define ROS_C_FREQ         5'h06
`define ROS_C_CURRENT      5'h07
`define ROS_C_BUS_V        5'h08
`define ROS_C_ANALOG_TWO   5'h09
`define ROS_C_PF_ANGLE     5'h0A
`define ROS_C_INPUT_LOSS   5'h0B
`define ROS_C_NETWORK      5'h0C
`define ROS_C_RETRIES      5'h0D
`define ROS_C_UNRECOV      5'h0E
`define ROS_C_REVERSE      5'h0F
`define ROS_C_LOGIC_ONE    5'h10
`define ROS_C_LOGIC_TWO    5'h11
`define ROS_C_AUX_MOTOR    5'h17
`define ROS_C_FAULT        5'h18

// delay tick timing
`define ROS_TICK_NS        100000000
`define ROS_CLK_NS         5

`endif

// ===== hdl/ros_pkg.sv
package ros_pkg;

	// relay delay sequencer
	typedef enum logic [1:0] {
		ROS_OFF,
		ROS_ON_WAIT,
		ROS_ON,
		ROS_OFF_WAIT
	} ros_state_t;

	typedef logic [4:0] ros_sel_t;

endpackage : ros_pkg

// ===== hdl/ros_relay.sv
// Functional notes
// - code 0: on when ready, off on fault
// - code 1: on at commanded frequency
// - code 2: on while motor powered
// - code 3: on under local control
// - codes 4,5: overload and ramp regulator
// - code 6: frequency above trip level
// - code 7: current above trip level
// - code 8: bus voltage above trip level
// - code 9: analog two above level, unipolar
// - code 10: power factor angle above level
// - code 11: loss on either analog input
// - code 12: network level drives relay directly
// - code 13: restart attempts exceeded
// - code 14: retries, unrecoverable, restart disabled
// - codes 15-17: reverse, logic inputs
// - code 23: auxiliary motor run
// - code 24: on when fault, inverse
// - trip level 0 to 9999, tenths
// - on-delay 0 to 600 s
// - off-delay 0 to 600 s
// - logic inputs only feed relay selection
`timescale 1ns/1ps
`default_nettype none
`include "ros_map.svh"

module ros_relay #(
	parameter int TICK_CYCLES = `ROS_TICK_NS / `ROS_CLK_NS
) (
	input  wire logic        clk_sys_i,
	input  wire logic        rst_n_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [31:0] pwdata_i,
	input  wire logic [3:0]  pstrb_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	input  wire logic        drive_ready_i,
	input  wire logic        fault_active_i,
	input  wire logic        speed_reached_i,
	input  wire logic        motor_powered_i,
	input  wire logic        local_control_i,
	input  wire logic        motor_overload_i,
	input  wire logic        ramp_reg_active_i,
	input  wire logic [15:0] out_freq_i,
	input  wire logic [15:0] out_current_i,
	input  wire logic [15:0] bus_voltage_i,
	input  wire logic [15:0] analog_two_i,
	input  wire logic [15:0] pf_angle_i,
	input  wire logic        analog_two_bipolar_i,
	input  wire logic        analog_one_loss_i,
	input  wire logic        analog_two_loss_i,
	input  wire logic        restart_exceeded_i,
	input  wire logic        unrecoverable_fault_i,
	input  wire logic        auto_restart_enabled_i,
	input  wire logic        reverse_cmd_i,
	input  wire logic        logic_in_one_i,
	input  wire logic        logic_in_two_i,
	input  wire logic        aux_motor_run_i,
	output logic             relay_coil_o
);

	// elaboration check on tick length
	// a tick is a one-cycle pulse, so the divider needs two cycles at least
	if (TICK_CYCLES < 2) begin : g_bad_tick
		$error("TICK_CYCLES must be at least two");
	end

	localparam int TW = $clog2(TICK_CYCLES + 1);

	ros_pkg::ros_sel_t    sel_q;
	logic [31:0]          level_q;
	logic [15:0]          on_dly_q;
	logic [15:0]          off_dly_q;
	logic [15:0]          cnt_q;
	logic [TW-1:0]        tick_cnt_q;
	logic                 tick_q;
	logic                 cond_d;
	logic                 cond_q;
	logic                 relay_q;
	ros_pkg::ros_state_t  state_q;
	logic                 setup_w;
	logic                 wr_w;
	logic                 mapped_w;

	// byte-lane merge of a write
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] st);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (st[i]) begin
				r[8*i +: 8] = wd[8*i +: 8];
			end
		end
		return r;
	endfunction : merge

	// measurement above trip level
	function automatic logic above(input logic [15:0] meas, input logic [31:0] lvl);
		return {16'h0000, meas} > lvl;
	endfunction : above

	// apb decode
	assign setup_w  = psel_i && !penable_i;
	assign wr_w     = psel_i && penable_i && pwrite_i;
	assign mapped_w = (paddr_i == `ROS_SEL_OFF) || (paddr_i == `ROS_LEVEL_OFF) ||
		(paddr_i == `ROS_ON_DLY_OFF) || (paddr_i == `ROS_OFF_DLY_OFF) ||
		(paddr_i == `ROS_STATUS_OFF);
	assign pready_o  = 1'b1;
	assign pslverr_o = psel_i && penable_i && !mapped_w;

	// selector register
	always_ff @(posedge clk_sys_i) begin
		logic [31:0] sv;
		sv = merge({27'h0, sel_q}, pwdata_i, pstrb_i);
		if (!rst_n_i) begin
			sel_q <= `ROS_SEL_RST;
		end else if (wr_w && paddr_i == `ROS_SEL_OFF) begin
			sel_q <= sv[4:0]; // code kept in the low five bits
		end
	end

	// trip level register, clamped to range
	always_ff @(posedge clk_sys_i) begin
		logic [31:0] nv;
		nv = merge(level_q, pwdata_i, pstrb_i);
		if (!rst_n_i) begin
			level_q <= `ROS_LEVEL_RST;
		end else if (wr_w && paddr_i == `ROS_LEVEL_OFF) begin
			level_q <= (nv > `ROS_LEVEL_MAX) ? `ROS_LEVEL_MAX : nv;
		end
	end

	// delay registers, clamped to 600 s
	always_ff @(posedge clk_sys_i) begin
		logic [31:0] on_v;
		logic [31:0] off_v;
		on_v  = merge({16'h0000, on_dly_q}, pwdata_i, pstrb_i);
		off_v = merge({16'h0000, off_dly_q}, pwdata_i, pstrb_i);
		if (!rst_n_i) begin
			on_dly_q  <= `ROS_DLY_RST;
			off_dly_q <= `ROS_DLY_RST;
		end else if (wr_w) begin
			if (paddr_i == `ROS_ON_DLY_OFF) begin
				on_dly_q <= (on_v > {16'h0000, `ROS_DLY_MAX}) ? `ROS_DLY_MAX
					: on_v[15:0];
			end
			if (paddr_i == `ROS_OFF_DLY_OFF) begin
				off_dly_q <= (off_v > {16'h0000, `ROS_DLY_MAX}) ? `ROS_DLY_MAX
					: off_v[15:0];
			end
		end
	end

	// read data captured in setup phase
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			prdata_o <= 32'h0000_0000;
		end else if (setup_w) begin
			case (paddr_i)
				`ROS_SEL_OFF:     prdata_o <= {27'h0, sel_q};
				`ROS_LEVEL_OFF:   prdata_o <= level_q;
				`ROS_ON_DLY_OFF:  prdata_o <= {16'h0000, on_dly_q};
				`ROS_OFF_DLY_OFF: prdata_o <= {16'h0000, off_dly_q};
				`ROS_STATUS_OFF: begin
					prdata_o <= {cnt_q, 12'h000,
						analog_two_bipolar_i && sel_q == `ROS_C_ANALOG_TWO,
						state_q == ros_pkg::ROS_ON_WAIT || state_q == ros_pkg::ROS_OFF_WAIT,
						cond_q, relay_q};
				end
				default:          prdata_o <= 32'h0000_0000;
			endcase
		end
	end

	// condition selection
	always_comb begin
		case (sel_q)
			`ROS_C_READY:      cond_d = drive_ready_i && !fault_active_i;
			`ROS_C_AT_SPEED:   cond_d = speed_reached_i;
			`ROS_C_POWERED:    cond_d = motor_powered_i;
			`ROS_C_LOCAL:      cond_d = local_control_i;
			`ROS_C_OVERLOAD:   cond_d = motor_overload_i;
			`ROS_C_RAMP_REG:   cond_d = ramp_reg_active_i;
			`ROS_C_FREQ:       cond_d = above(out_freq_i, level_q);
			`ROS_C_CURRENT:    cond_d = above(out_current_i, level_q);
			`ROS_C_BUS_V:      cond_d = above(bus_voltage_i, level_q);
			`ROS_C_ANALOG_TWO: begin
				cond_d = !analog_two_bipolar_i && above(analog_two_i, level_q);
			end
			`ROS_C_PF_ANGLE:   cond_d = above(pf_angle_i, level_q);
			`ROS_C_INPUT_LOSS: cond_d = analog_one_loss_i || analog_two_loss_i;
			`ROS_C_NETWORK:    cond_d = level_q != 32'h0000_0000;
			`ROS_C_RETRIES:    cond_d = restart_exceeded_i;
			`ROS_C_UNRECOV: begin
				cond_d = restart_exceeded_i || unrecoverable_fault_i ||
					!auto_restart_enabled_i;
			end
			`ROS_C_REVERSE:    cond_d = reverse_cmd_i;
			`ROS_C_LOGIC_ONE:  cond_d = logic_in_one_i;
			`ROS_C_LOGIC_TWO:  cond_d = logic_in_two_i;
			`ROS_C_AUX_MOTOR:  cond_d = aux_motor_run_i;
			`ROS_C_FAULT:      cond_d = fault_active_i;
			default:           cond_d = 1'b0;
		endcase
	end

	// condition register
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			cond_q <= 1'b0;
		end else begin
			cond_q <= cond_d;
		end
	end

	// 0.1 s tick divider
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			tick_cnt_q <= '0;
			tick_q     <= 1'b0;
		end else if (tick_cnt_q == TW'(TICK_CYCLES - 1)) begin
			tick_cnt_q <= '0;
			tick_q     <= 1'b1;
		end else begin
			tick_cnt_q <= tick_cnt_q + 1'b1;
			tick_q     <= 1'b0;
		end
	end

	// on/off delay sequencer
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			state_q <= ros_pkg::ROS_OFF;
			cnt_q   <= 16'h0000;
			relay_q <= 1'b0;
		end else begin
			case (state_q)
				ros_pkg::ROS_OFF: begin
					cnt_q <= 16'h0000;
					if (cond_q) begin
						state_q <= ros_pkg::ROS_ON_WAIT;
					end
				end
				ros_pkg::ROS_ON_WAIT: begin
					if (!cond_q) begin
						state_q <= ros_pkg::ROS_OFF;
						cnt_q   <= 16'h0000;
					end else if (tick_q) begin
						if (cnt_q >= on_dly_q) begin
							state_q <= ros_pkg::ROS_ON;
							relay_q <= 1'b1;
							cnt_q   <= 16'h0000;
						end else begin
							cnt_q <= cnt_q + 16'h0001;
						end
					end
				end
				ros_pkg::ROS_ON: begin
					cnt_q <= 16'h0000;
					if (!cond_q) begin
						state_q <= ros_pkg::ROS_OFF_WAIT;
					end
				end
				ros_pkg::ROS_OFF_WAIT: begin
					if (cond_q) begin
						state_q <= ros_pkg::ROS_ON;
						cnt_q   <= 16'h0000;
					end else if (tick_q) begin
						if (cnt_q >= off_dly_q) begin
							state_q <= ros_pkg::ROS_OFF;
							relay_q <= 1'b0;
							cnt_q   <= 16'h0000;
						end else begin
							cnt_q <= cnt_q + 16'h0001;
						end
					end
				end
				default: begin
					state_q <= ros_pkg::ROS_OFF;
					relay_q <= 1'b0;
					cnt_q   <= 16'h0000;
				end
			endcase
		end
	end

	assign relay_coil_o = relay_q;

	// checks
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);

	sequence s_sel_held;
		$stable(sel_q) && $stable(level_q);
	endsequence

	sequence s_on_done;
		state_q == ros_pkg::ROS_ON_WAIT && cond_q && tick_q && cnt_q >= on_dly_q;
	endsequence

	sequence s_off_done;
		state_q == ros_pkg::ROS_OFF_WAIT && !cond_q && tick_q && cnt_q >= off_dly_q;
	endsequence

	a_ready_fault: assert property (
		sel_q == `ROS_C_READY ##1 s_sel_held |->
			cond_q == ($past(drive_ready_i) && !$past(fault_active_i)))
		else $error("ready condition mismatch");

	a_fault_inverse: assert property (
		sel_q == `ROS_C_FAULT ##1 s_sel_held |-> cond_q == $past(fault_active_i))
		else $error("fault condition mismatch");

	a_freq_compare: assert property (
		sel_q == `ROS_C_FREQ ##1 s_sel_held |->
			cond_q == ({16'h0000, $past(out_freq_i)} > level_q))
		else $error("frequency compare mismatch");

	a_bipolar_block: assert property (
		sel_q == `ROS_C_ANALOG_TWO && analog_two_bipolar_i |=> !cond_q)
		else $error("bipolar analog two raised condition");

	a_net_direct: assert property (
		sel_q == `ROS_C_NETWORK ##1 s_sel_held |-> cond_q == (level_q != 32'h0000_0000))
		else $error("network drive mismatch");

	a_restart_or: assert property (
		sel_q == `ROS_C_UNRECOV && !auto_restart_enabled_i ##1 s_sel_held |-> cond_q)
		else $error("restart disabled not reflected");

	a_level_range: assert property (
		level_q <= `ROS_LEVEL_MAX)
		else $error("trip level above range");

	a_delay_range: assert property (
		on_dly_q <= `ROS_DLY_MAX && off_dly_q <= `ROS_DLY_MAX)
		else $error("delay above range");

	a_relay_on: assert property (
		s_on_done |=> relay_q && state_q == ros_pkg::ROS_ON)
		else $error("relay did not energize after on-delay");

	a_relay_off: assert property (
		s_off_done |=> !relay_q && state_q == ros_pkg::ROS_OFF)
		else $error("relay did not release after off-delay");

	a_rise_cause: assert property (
		$rose(relay_q) |-> $past(tick_q) && $past(cond_q) &&
			$past(state_q) == ros_pkg::ROS_ON_WAIT)
		else $error("relay rose without tick and condition");

	a_tick_period: assert property (
		tick_q |=> !tick_q)
		else $error("tick longer than one cycle");

	a_abort_on: assert property (
		state_q == ros_pkg::ROS_ON_WAIT && !cond_q |=> state_q == ros_pkg::ROS_OFF && !relay_q)
		else $error("pending on-delay not cancelled");

	a_abort_off: assert property (
		state_q == ros_pkg::ROS_OFF_WAIT && cond_q |=> state_q == ros_pkg::ROS_ON && relay_q)
		else $error("pending off-delay not cancelled");

	a_fall_cause: assert property (
		$fell(relay_q) |-> $past(tick_q) && !$past(cond_q) &&
			$past(state_q) == ros_pkg::ROS_OFF_WAIT)
		else $error("relay fell without tick and released condition");

	a_input_loss: assert property (
		sel_q == `ROS_C_INPUT_LOSS ##1 s_sel_held |->
			cond_q == ($past(analog_one_loss_i) || $past(analog_two_loss_i)))
		else $error("input loss condition mismatch");

endmodule : ros_relay
`default_nettype wire

// ===== tb/ros_status_model.sv
`timescale 1ns/1ps
`default_nettype none
module ros_status_model (
	input  wire logic [16:0] flags_i,
	input  wire logic [15:0] meas_i,
	output logic      [16:0] flags_o,
	output logic      [15:0] meas_o
);
	// status levels; logic inputs carry only their level
	assign flags_o = flags_i;
	// one reading feeds every measured channel
	assign meas_o  = meas_i;
endmodule : ros_status_model
`default_nettype wire

// ===== tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "ros_map.svh"
module tb;
	logic        clk, rst_n, psel, penable, pwrite, rly, rdy, err, e;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, s, r, lvl;
	logic [16:0] fl, st;
	logic [15:0] ms, meas;
	int          failures, comparisons, n, i, j;
	int          codes [22] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 12, 13, 14, 15, 16,
		17, 23, 24, 18, 31};

	ros_status_model mdl_u (.flags_i(fl), .meas_i(ms), .flags_o(st), .meas_o(meas));
	ros_relay #(.TICK_CYCLES(4)) dut_u (.clk_sys_i(clk), .rst_n_i(rst_n), .paddr_i(paddr),
		.psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata),
		.pstrb_i(4'hf), .prdata_o(prdata), .pready_o(rdy), .pslverr_o(err),
		.drive_ready_i(st[0]), .fault_active_i(st[1]), .speed_reached_i(st[2]),
		.motor_powered_i(st[3]), .local_control_i(st[4]), .motor_overload_i(st[5]),
		.ramp_reg_active_i(st[6]), .out_freq_i(meas), .out_current_i(meas),
		.bus_voltage_i(meas), .analog_two_i(meas), .pf_angle_i(meas),
		.analog_two_bipolar_i(st[7]), .analog_one_loss_i(st[8]), .analog_two_loss_i(st[9]),
		.restart_exceeded_i(st[10]), .unrecoverable_fault_i(st[11]),
		.auto_restart_enabled_i(st[12]), .reverse_cmd_i(st[13]), .logic_in_one_i(st[14]),
		.logic_in_two_i(st[15]), .aux_motor_run_i(st[16]), .relay_coil_o(rly));

	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : lfsr

	// expected relay condition for a code
	function automatic logic exp_cond(input int c, input logic [16:0] f, input logic [15:0] m,
		input logic [31:0] l);
		case (c)
			0: return f[0] & ~f[1];
			1: return f[2];
			2: return f[3];
			3: return f[4];
			4: return f[5];
			5: return f[6];
			6, 7, 8, 10: return {16'h0000, m} > l;
			9: return ({16'h0000, m} > l) & ~f[7];
			11: return f[8] | f[9];
			12: return l != 32'h0000_0000;
			13: return f[10];
			14: return f[10] | f[11] | ~f[12];
			15: return f[13];
			16: return f[14];
			17: return f[15];
			23: return f[16];
			24: return f[1];
			default: return 1'b0;
		endcase
	endfunction : exp_cond

	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_reg

	task automatic chk_bit(input logic got, input logic exp);
		chk_reg({31'h0, got}, {31'h0, exp});
	endtask : chk_bit

	// one apb transfer, read data and error kept in r and e
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		// only the watchdog ends a wait for the answer
		while (rdy !== 1'b1) begin
			@(posedge clk);
		end
		r = prdata;
		e = err;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// relay must hold level v for 40 cycles
	task automatic stay(input logic v);
		n = 0;
		repeat (40) begin
			@(posedge clk);
			if (rly !== v) n++;
		end
		chk_bit(n == 0, 1'b1);
	endtask : stay

	task complete_run;
		$display("failures=%0d comparisons=%0d", failures, comparisons);
		if (failures == 0 && comparisons > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : complete_run

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// watchdog
	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		complete_run();
	end

	// main sequence
	initial begin
		{rst_n, psel, penable, pwrite, paddr, pwdata, fl, ms} = '0;
		failures = 0;
		comparisons = 0;
		s = 32'h0001_6b20;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		chk_bit(rly, 1'b0);
		for (i = 0; i < 4; i++) begin
			apb(1'b0, 8'(4 * i), 32'h0000_0000);
			chk_reg(r, 32'h0000_0000);
			chk_bit(e, 1'b0);
		end
		apb(1'b1, `ROS_LEVEL_OFF, 32'hffff_ffff);
		apb(1'b0, `ROS_LEVEL_OFF, 32'h0000_0000);
		chk_reg(r, 32'h0001_8696);
		apb(1'b1, `ROS_ON_DLY_OFF, 32'h0000_ffff);
		apb(1'b0, `ROS_ON_DLY_OFF, 32'h0000_0000);
		chk_reg(r, 32'h0000_1770);
		apb(1'b1, `ROS_ON_DLY_OFF, 32'h0000_0000);
		apb(1'b0, 8'h14, 32'h0000_0000);
		chk_bit(e, 1'b1);
		chk_reg(r, 32'h0000_0000);
		// every defined code plus undefined codes 18 and 31, with random status and levels near the reading
		for (i = 0; i < 22; i++) begin
			apb(1'b1, `ROS_SEL_OFF, 32'(codes[i]));
			for (j = 0; j < 4; j++) begin
				s = lfsr(lfsr(s));
				lvl = (codes[i] == 12) ? {31'h0, s[0]} : {16'h0000, s[31:16]};
				apb(1'b1, `ROS_LEVEL_OFF, lvl);
				fl <= s[16:0];
				ms <= lvl[15:0] ^ {14'h0, s[18:17]};
				repeat (20) @(posedge clk);
				chk_bit(rly, exp_cond(codes[i], fl, ms, lvl));
				if (codes[i] == 9) begin
					apb(1'b0, `ROS_STATUS_OFF, 32'h0000_0000);
					chk_bit(r[3], fl[7]);
				end
			end
		end
		// delays on the motor powered code
		apb(1'b1, `ROS_SEL_OFF, 32'h0000_0002);
		fl <= '0;
		apb(1'b1, `ROS_ON_DLY_OFF, 32'h0000_0003);
		repeat (20) @(posedge clk);
		fl <= 17'h0_0008;
		n = 0;
		while (rly !== 1'b1 && n < 40) begin
			@(posedge clk);
			n++;
		end
		chk_bit(n >= 12 && n <= 20, 1'b1);
		apb(1'b1, `ROS_OFF_DLY_OFF, 32'h0000_0002); // aux motor code unused here
		fl <= '0;
		repeat (6) @(posedge clk);
		chk_bit(rly, 1'b1);
		repeat (14) @(posedge clk);
		chk_bit(rly, 1'b0);
		fl <= 17'h0_0008;
		repeat (4) @(posedge clk);
		fl <= '0;
		stay(1'b0);
		fl <= 17'h0_0008;
		repeat (24) @(posedge clk);
		fl <= '0;
		repeat (4) @(posedge clk);
		fl <= 17'h0_0008;
		stay(1'b1);
		complete_run();
	end
endmodule : tb
`default_nettype wire
